// file: bvrc_cfg.svh
// Constants and operation list for the boot vector reset control block
`ifndef BVRC_CFG_SVH
`define BVRC_CFG_SVH
`define BVRC_NUM_DS       2
`define BVRC_MODE_W       3
`define BVRC_MODE_NORMAL  3'h0
`define BVRC_MODE_EEPROM  3'h1
`define BVRC_PULSE_W      4
`define BVRC_PULSE_CYC    4'h8
`define BVRC_PULSE_ZERO   4'h0
`define BVRC_PULSE_ONE    4'h1
`endif

// file: bvrc_pkg.sv
// Types for the boot vector reset control block
package bvrc_pkg;
   typedef struct packed {
      logic       downstream_common_clock_strap;
      logic       upstream_common_clock_strap;
      logic       reset_halt_strap;
      logic [2:0] switch_mode_straps;
      logic       aux_power_disable_n;
   } bvrc_vec_t;
   typedef enum logic [3:0] {
      BVRC_ST_FRESET = 4'h1,
      BVRC_ST_INIT   = 4'h2,
      BVRC_ST_HALT   = 4'h4,
      BVRC_ST_RUN    = 4'h8
   } bvrc_state_t;
endpackage

// file: bvrc_src_model.sv
// Reset source and strap pin model for the boot vector reset control block
`timescale 1ns/100ps
module bvrc_src (
   input  wire logic                clk,                            // Core clock
   input  wire logic                sys_rst,                        // Bench reset
   input  wire logic                start,                          // Begin pin reset
   input  wire logic                cold,                           // With power-on
   input  wire bvrc_pkg::bvrc_vec_t vec,                            // Straps to show
   output logic                     fundamental_reset_pin_n = 1'b0, // Reset pin
   output logic                     power_on_rst = 1'b1,            // Power-on pulse
   output bvrc_pkg::bvrc_vec_t      strap_in = 7'h00                // Strap pins
);
   logic [3:0] cnt = 4'h6;
   // ****************************************
   // Pin reset sequence
   // ****************************************
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= 4'h6;
         fundamental_reset_pin_n <= 1'b0;
         power_on_rst <= 1'b1;
         strap_in <= vec;
      end else begin
         cnt <= start ? 4'h6 : cnt - {3'h0, cnt != 4'h0};
         fundamental_reset_pin_n <= !(start || cnt > 4'h1);
         power_on_rst <= start && cold;
         // Straps flip every cycle past the capture edge, so late sampling shows
         strap_in <= (start || cnt != 4'h0) ? vec : ~strap_in;
      end
   end
endmodule

// file: bvrc_top.sv
// Boot vector capture, reset halt and reset category sorting
`timescale 1ns/100ps
`include "bvrc_cfg.svh"
module bvrc_top (
   input  wire logic                      clk,                 // Core clock
   input  wire logic                      sys_rst,             // Async reset, high
   input  wire logic                      clk_en,              // Freezes state when low
   input  wire logic                      power_on_rst,        // Power-on pulse
   input  wire logic                      fundamental_reset_pin_n, // Reset pin, low active
   input  wire bvrc_pkg::bvrc_vec_t       strap_in,            // Strap pins
   input  wire logic                      warm_reset_trigger_bit, // Control bit write one
   input  wire logic                      halt_clear,          // SMBus clears halt bit
   input  wire logic                      halt_set,            // SMBus sets halt bit
   input  wire logic                      ovr_valid,           // EEPROM override write
   input  wire bvrc_pkg::bvrc_vec_t       ovr_vec,             // EEPROM override value
   input  wire logic                      hot_reset_req,       // Hot reset request
   input  wire logic                      us_sec_bus_reset,    // Upstream sec bus reset
   input  wire logic [`BVRC_NUM_DS-1:0]   ds_sec_bus_reset,    // Downstream sec bus reset
   input  wire logic                      us_sclk_wr,          // Software writes upstream bit
   input  wire logic                      us_sclk_wdata,       // Upstream write value
   input  wire logic [`BVRC_NUM_DS-1:0]   ds_sclk_wr,          // Software writes ds bits
   input  wire logic [`BVRC_NUM_DS-1:0]   ds_sclk_wdata,       // Downstream write values
   output bvrc_pkg::bvrc_vec_t            switch_status_reg,   // Straps from last cold reset
   output logic                           status_halt,         // Halt seen in reset sequence
   output logic                           control_halt,        // Control halt bit
   output bvrc_pkg::bvrc_vec_t            boot_vec,            // Active boot vector
   output logic                           us_link_sclk,        // Upstream slot clock bit
   output logic [`BVRC_NUM_DS-1:0]        ds_link_sclk,        // Downstream slot clock bits
   output logic                           mode_eeprom,         // EEPROM init mode
   output logic                           mode_reserved,       // Reserved mode code
   output logic                           aux_power_en,        // Aux power logic enabled
   output logic                           sticky_rst,          // Clear sticky fields
   output logic                           core_rst,            // Reset non-sticky logic
   output logic                           smbus_master_en,     // Master SMBus running
   output logic                           vbus_hot_rst,        // Internal bus hot reset
   output logic [`BVRC_NUM_DS-1:0]        ds_link_hot_rst,     // Hot reset on ds link
   output logic                           fund_is_cold         // Last fundamental was cold
);
   // ****************************************
   // Reset sequence control
   // ****************************************
   bvrc_pkg::bvrc_state_t state;
   bvrc_pkg::bvrc_state_t next_state;
   logic pin_q;
   logic cold_pending;
   logic pin_seen;
   logic [`BVRC_PULSE_W-1:0] hot_cnt;
   logic [`BVRC_PULSE_W-1:0] next_hot_cnt;
   logic [`BVRC_NUM_DS-1:0] ds_hot;
   logic hot_full;

   wire pin_asserted = !fundamental_reset_pin_n;
   wire pin_release  = pin_q && fundamental_reset_pin_n;
   wire in_freset    = (state == bvrc_pkg::BVRC_ST_FRESET);
   // Warm entry: pin while powered or trigger bit
   wire warm_entry   = (pin_asserted || warm_reset_trigger_bit) && !in_freset;
   wire exit_freset  = in_freset && (pin_seen ? pin_release : fundamental_reset_pin_n);
   // Sample only in fundamental reset at pin release
   wire capture      = exit_freset && pin_seen;
   wire reuse        = exit_freset && !pin_seen;
   wire hot_any      = hot_reset_req || us_sec_bus_reset;
   wire hot_load     = hot_any && (state == bvrc_pkg::BVRC_ST_RUN);
   wire [`BVRC_MODE_W-1:0] mode = boot_vec.switch_mode_straps;

   // Override keeps sampled switch mode, the other fields follow EEPROM
   bvrc_pkg::bvrc_vec_t ovr_merged;
   assign ovr_merged = '{downstream_common_clock_strap: ovr_vec.downstream_common_clock_strap,
                         upstream_common_clock_strap:   ovr_vec.upstream_common_clock_strap,
                         reset_halt_strap:              ovr_vec.reset_halt_strap,
                         switch_mode_straps:            boot_vec.switch_mode_straps,
                         aux_power_disable_n:           ovr_vec.aux_power_disable_n};

   // EEPROM write in INIT lands with the sclk load, so both see the new value
   bvrc_pkg::bvrc_vec_t init_vec;
   assign init_vec = ovr_valid ? ovr_merged : boot_vec;
   wire halt_start = init_vec.reset_halt_strap;

   always_comb begin
      next_state = state;
      unique case (state)
         bvrc_pkg::BVRC_ST_FRESET: begin
            if (exit_freset) begin
               next_state = bvrc_pkg::BVRC_ST_INIT;
            end
         end
         bvrc_pkg::BVRC_ST_INIT: begin
            if (halt_start) begin
               next_state = bvrc_pkg::BVRC_ST_HALT;
            end else begin
               next_state = bvrc_pkg::BVRC_ST_RUN;
            end
         end
         bvrc_pkg::BVRC_ST_HALT: begin
            if (halt_clear && !halt_set) begin
               next_state = bvrc_pkg::BVRC_ST_RUN;
            end
         end
         bvrc_pkg::BVRC_ST_RUN: begin
            next_state = bvrc_pkg::BVRC_ST_RUN;
         end
         default: begin
            next_state = bvrc_pkg::BVRC_ST_FRESET;
         end
      endcase
      if (warm_entry) begin
         next_state = bvrc_pkg::BVRC_ST_FRESET;
      end
   end

   always_comb begin
      next_hot_cnt = hot_cnt;
      if (hot_load) begin
         next_hot_cnt = `BVRC_PULSE_CYC;
      end else if (hot_cnt != `BVRC_PULSE_ZERO) begin
         next_hot_cnt = hot_cnt - `BVRC_PULSE_ONE;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= bvrc_pkg::BVRC_ST_FRESET;
         pin_q <= 1'b0;
         hot_cnt <= `BVRC_PULSE_ZERO;
         hot_full <= 1'b0;
      end else if (clk_en) begin
         state <= power_on_rst ? bvrc_pkg::BVRC_ST_FRESET : next_state;
         pin_q <= pin_asserted;
         hot_cnt <= next_hot_cnt;
         // Request is a pulse; remember if this is a full hot reset or bus only
         if (hot_load) begin
            hot_full <= hot_reset_req;
         end
      end
   end

   // Cold or warm tag and pin tracking for this sequence
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cold_pending <= 1'b1;
         pin_seen <= 1'b1;
         fund_is_cold <= 1'b1;
      end else if (clk_en) begin
         if (power_on_rst) begin
            cold_pending <= 1'b1;
            pin_seen <= 1'b0;
         end else if (warm_entry) begin
            pin_seen <= pin_asserted;
         end else if (in_freset && pin_asserted) begin
            pin_seen <= 1'b1;
         end else if (capture) begin
            cold_pending <= 1'b0;
            fund_is_cold <= cold_pending;
         end else if (reuse) begin
            fund_is_cold <= 1'b0;
         end
      end
   end

   // ****************************************
   // Boot vector capture and status
   // ****************************************
   // Reset value is the strap pull default; capture replaces it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         boot_vec <= '0;
         switch_status_reg <= '0;
      end else if (clk_en) begin
         if (capture) begin
            boot_vec <= strap_in;
            if (cold_pending) begin
               switch_status_reg <= strap_in;
            end
         end else if (ovr_valid && state == bvrc_pkg::BVRC_ST_INIT) begin
            boot_vec <= ovr_merged;
         end
      end
   end

   // Halt bits: set wins over a same-cycle clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_halt <= 1'b0;
         control_halt <= 1'b0;
      end else if (clk_en) begin
         if (state == bvrc_pkg::BVRC_ST_INIT) begin
            status_halt <= halt_start;
            control_halt <= halt_start;
         end else if (halt_set) begin
            control_halt <= 1'b1;
         end else if (halt_clear) begin
            control_halt <= 1'b0;
         end
      end
   end

   // ****************************************
   // Slot clock configuration bits
   // ****************************************
   wire load_sclk = (state == bvrc_pkg::BVRC_ST_INIT);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         us_link_sclk <= 1'b0;
      end else if (clk_en) begin
         if (load_sclk) begin
            us_link_sclk <= init_vec.upstream_common_clock_strap;
         end else if (us_sclk_wr) begin
            us_link_sclk <= us_sclk_wdata;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < `BVRC_NUM_DS; g++) begin : g_ds
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               ds_link_sclk[g] <= 1'b0;
               ds_hot[g] <= 1'b0;
               ds_link_hot_rst[g] <= 1'b0;
            end else if (clk_en) begin
               if (load_sclk) begin
                  ds_link_sclk[g] <= init_vec.downstream_common_clock_strap;
               end else if (ds_sclk_wr[g]) begin
                  ds_link_sclk[g] <= ds_sclk_wdata[g];
               end
               ds_hot[g] <= ds_sec_bus_reset[g];
               // Held as long as the bridge control bit stays set
               ds_link_hot_rst[g] <= ds_hot[g] && state == bvrc_pkg::BVRC_ST_RUN;
            end
         end
      end
   endgenerate

   // ****************************************
   // Mode decode and reset outputs
   // ****************************************
   wire running   = (state == bvrc_pkg::BVRC_ST_RUN);
   wire next_aux  = boot_vec.aux_power_disable_n;
   // No aux power: sticky fields cannot be kept, so clear them
   wire next_sticky = in_freset || !next_aux;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_eeprom <= 1'b0;
         mode_reserved <= 1'b0;
         aux_power_en <= 1'b0;
         sticky_rst <= 1'b1;
         core_rst <= 1'b1;
         smbus_master_en <= 1'b0;
         vbus_hot_rst <= 1'b0;
      end else if (clk_en) begin
         mode_eeprom <= (mode == `BVRC_MODE_EEPROM);
         mode_reserved <= (mode != `BVRC_MODE_NORMAL) && (mode != `BVRC_MODE_EEPROM);
         aux_power_en <= next_aux;
         sticky_rst <= next_sticky;
         core_rst <= !running || (hot_cnt != `BVRC_PULSE_ZERO && hot_full);
         smbus_master_en <= !in_freset;
         // Upstream bridge keeps running on a bus-only reset; a full hot reset also raises core_rst
         vbus_hot_rst <= hot_cnt != `BVRC_PULSE_ZERO;
      end
   end
endmodule

// file: bvrc_top_checker.sv
// Port assertions for the boot vector reset control block
`timescale 1ns/100ps
`include "bvrc_cfg.svh"
module bvrc_chk (
   input wire logic                    clk,                     // Core clock
   input wire logic                    sys_rst,                 // Async reset
   input wire logic                    clk_en,                  // State enable
   input wire logic                    fundamental_reset_pin_n, // Reset pin
   input wire bvrc_pkg::bvrc_vec_t     strap_in,                // Strap pins
   input wire logic                    ovr_valid,               // Override write
   input wire logic [`BVRC_NUM_DS-1:0] ds_sec_bus_reset,        // Ds sec reset
   input wire bvrc_pkg::bvrc_vec_t     switch_status_reg,       // Cold straps
   input wire bvrc_pkg::bvrc_vec_t     boot_vec,                // Active vector
   input wire logic                    mode_eeprom,             // Mode one
   input wire logic                    mode_reserved,           // Mode two up
   input wire logic                    aux_power_en,            // Aux enabled
   input wire logic                    sticky_rst,              // Sticky clear
   input wire logic                    core_rst,                // Core reset
   input wire logic                    vbus_hot_rst,            // Bus hot reset
   input wire logic [`BVRC_NUM_DS-1:0] ds_link_hot_rst          // Ds link hot reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ****************************************
   // Capture, decode and reset reach
   // ****************************************
   chk_strap_capture: assert property ($rose(fundamental_reset_pin_n) && clk_en && $past(clk_en)
      |=> boot_vec == $past(strap_in)) else $error("vector not captured at release");
   chk_strap_ignored: assert property (!$rose(fundamental_reset_pin_n) && !ovr_valid
      |=> $stable(boot_vec)) else $error("vector moved outside capture");
   chk_mode_fixed: assert property (ovr_valid && !$rose(fundamental_reset_pin_n)
      |=> $stable(boot_vec.switch_mode_straps)) else $error("mode field overridden");
   chk_status_hold: assert property (!$rose(fundamental_reset_pin_n)
      |=> $stable(switch_status_reg)) else $error("status moved outside capture");
   chk_mode_decode: assert property ((clk_en && $stable(boot_vec)) [*3] |->
      mode_eeprom == (boot_vec.switch_mode_straps == `BVRC_MODE_EEPROM) &&
      mode_reserved == (boot_vec.switch_mode_straps > `BVRC_MODE_EEPROM)) else $error("mode decode");
   chk_aux_decode: assert property ((clk_en && $stable(boot_vec)) [*3]
      |-> aux_power_en == boot_vec.aux_power_disable_n) else $error("aux enable decode");
   chk_ds_delay: assert property ($past(clk_en) && $past(clk_en, 2)
      |-> ds_link_hot_rst == $past(ds_sec_bus_reset, 2)) else $error("link hot reset timing");
   chk_core_fund: assert property ((!fundamental_reset_pin_n && clk_en) [*3]
      |-> core_rst && sticky_rst) else $error("pin reset missed logic");
   chk_hot_length: assert property ($rose(vbus_hot_rst) |-> vbus_hot_rst [*8])
      else $error("hot reset pulse short");
   cover property ($rose(fundamental_reset_pin_n));
   cover property ($rose(vbus_hot_rst) && core_rst);
   cover property (mode_reserved && !core_rst);
endmodule
bind bvrc_top bvrc_chk u_chk (.*);

// file: bvrc_top_test.sv
// Self-checking bench for the boot vector reset control block
`timescale 1ns/100ps
`include "bvrc_cfg.svh"
module bvrc_top_test;
   logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, start = 1'b0, cold = 1'b0;
   logic warm_reset_trigger_bit = 1'b0, halt_clear = 1'b0, halt_set = 1'b0, ovr_valid = 1'b0;
   logic hot_reset_req = 1'b0, us_sec_bus_reset = 1'b0, us_sclk_wr = 1'b0, us_sclk_wdata = 1'b0;
   logic [1:0] ds_sec_bus_reset = 2'h0, ds_sclk_wr = 2'h0, ds_sclk_wdata = 2'h0;
   logic [1:0] ds_link_sclk, ds_link_hot_rst;
   logic power_on_rst, fundamental_reset_pin_n, status_halt, control_halt, us_link_sclk;
   logic mode_eeprom, mode_reserved, aux_power_en, sticky_rst, core_rst, smbus_master_en;
   logic vbus_hot_rst, fund_is_cold;
   bvrc_pkg::bvrc_vec_t vec = 7'h00, ovr_vec = 7'h00, last_bv = 7'h00, v0, v;
   bvrc_pkg::bvrc_vec_t strap_in, switch_status_reg, boot_vec, exp_q[$];
   int miscompares = 0, num_checks = 0, n, k;
   bvrc_top uut (.*);
   bvrc_src src (.*);
   initial forever #2.5 clk = ~clk;
   task end_of_test;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk_vec(input logic [6:0] got, input logic [6:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      chk_vec({6'h0, got}, {6'h0, exp});
   endtask
   task wait_on(input logic hot, input logic lvl);
      n = 0;
      while ((hot ? vbus_hot_rst : core_rst) !== lvl && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n == 200) begin
         miscompares++;
         end_of_test();
      end
   endtask
   // Any vector change must match the oldest expected capture
   always @(negedge clk) if (!sys_rst && boot_vec !== last_bv) begin
      if (exp_q.size() == 0) chk_vec(boot_vec, last_bv);
      else chk_vec(boot_vec, exp_q.pop_front());
      last_bv = boot_vec;
   end
   task look(input bvrc_pkg::bvrc_vec_t x, input logic c);
      repeat (3) @(negedge clk);
      chk_vec(switch_status_reg, v0);
      chk_vec({5'h0, ds_link_sclk}, {5'h0, {2{x.downstream_common_clock_strap}}});
      chk_bit(us_link_sclk, x.upstream_common_clock_strap);
      chk_bit(mode_eeprom, x.switch_mode_straps == `BVRC_MODE_EEPROM);
      chk_bit(mode_reserved, x.switch_mode_straps > `BVRC_MODE_EEPROM);
      chk_bit(aux_power_en, x.aux_power_disable_n);
      chk_bit(fund_is_cold, c);
      chk_bit(control_halt, 1'b0);
   endtask
   task boot(input logic c, input bvrc_pkg::bvrc_vec_t x);
      @(posedge clk);
      vec <= x;
      start <= 1'b1;
      cold <= c;
      exp_q.push_back(x);
      if (c) v0 = x;
      // EEPROM write in INIT replaces all but the mode field
      if (ovr_valid) begin
         x = {ovr_vec[6:4], x[3:1], ovr_vec[0]};
         exp_q.push_back(x);
      end
      @(posedge clk);
      start <= 1'b0;
      wait_on(1'b0, 1'b1);
      if (x.reset_halt_strap) begin
         repeat (12) @(negedge clk);
         chk_bit(core_rst & control_halt & status_halt & smbus_master_en, 1'b1);
         @(posedge clk);
         {halt_set, halt_clear} <= 2'h3;
         @(posedge clk);
         halt_set <= 1'b0;
         @(negedge clk);
         chk_bit(control_halt & core_rst, 1'b1);
         @(posedge clk);
         halt_clear <= 1'b0;
      end
      wait_on(1'b0, 1'b0);
      look(x, c);
   endtask
   task hot(input logic h);
      @(posedge clk);
      hot_reset_req <= h;
      us_sec_bus_reset <= !h;
      @(posedge clk);
      hot_reset_req <= 1'b0;
      us_sec_bus_reset <= 1'b0;
      wait_on(1'b1, 1'b1);
      k = 0;
      while (vbus_hot_rst === 1'b1 && k < 20) begin
         if (k == 4) chk_vec({5'h0, sticky_rst, core_rst}, {6'h0, h});
         k++;
         @(negedge clk);
      end
      chk_vec(k[6:0], 7'h08);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(70329));
      v0 = 7'($urandom) | 7'h01;
      v0.reset_halt_strap = 1'b0;
      v0.switch_mode_straps = `BVRC_MODE_NORMAL;
      vec = v0;
      exp_q.push_back(v0);
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      wait_on(1'b0, 1'b0);
      look(v0, 1'b1);
      repeat (40) begin
         @(posedge clk);
         clk_en <= 1'($urandom);
         ovr_valid <= 1'($urandom);
         ovr_vec <= 7'($urandom);
         ds_sec_bus_reset <= 2'($urandom);
      end
      @(posedge clk);
      {clk_en, ovr_valid, ds_sec_bus_reset} <= 4'h8;
      us_sclk_wr <= 1'b1;
      us_sclk_wdata <= ~v0.upstream_common_clock_strap;
      ds_sclk_wr <= 2'h1;
      ds_sclk_wdata <= {2{~v0.downstream_common_clock_strap}};
      @(posedge clk);
      {us_sclk_wr, ds_sclk_wr} <= 3'h0;
      @(negedge clk);
      chk_bit(us_link_sclk, ~v0.upstream_common_clock_strap);
      chk_vec({5'h0, ds_link_sclk}, {5'h0, v0.downstream_common_clock_strap,
         ~v0.downstream_common_clock_strap});
      for (int i = 1; i < 9; i++) begin
         v = 7'($urandom);
         v.switch_mode_straps = i[2:0];
         v.reset_halt_strap = (i == 5);
         boot(1'b0, v);
      end
      @(posedge clk);
      warm_reset_trigger_bit <= 1'b1;
      @(posedge clk);
      warm_reset_trigger_bit <= 1'b0;
      wait_on(1'b0, 1'b1);
      wait_on(1'b0, 1'b0);
      look(v, 1'b0);
      v = 7'($urandom) | 7'h01;
      v.reset_halt_strap = 1'b0;
      v.switch_mode_straps = `BVRC_MODE_EEPROM;
      ovr_valid <= 1'b1;
      ovr_vec <= {~v[6:5], 4'h0, 1'b1};
      boot(1'b1, v);
      ovr_valid <= 1'b0;
      hot(1'b1);
      hot(1'b0);
      @(posedge clk);
      ds_sec_bus_reset <= 2'h2;
      @(posedge clk);
      ds_sec_bus_reset <= 2'h0;
      repeat (2) @(negedge clk);
      chk_vec({5'h0, ds_link_hot_rst}, 7'h02);
      @(negedge clk);
      chk_vec({5'h0, ds_link_hot_rst}, 7'h00);
      repeat (5) @(negedge clk);
      chk_bit(exp_q.size() == 0, 1'b1);
      end_of_test();
   end
endmodule
